// [core/level_sync.sv]
// Two flip-flop synchroniser for levels arriving from outside the clock.
// Assumes each bit is an independent slow level.
`timescale 1ns/100ps

module level_sync
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  generate
    if (WIDTH < 1)
    begin : g_bad_width
      $error("level_sync: WIDTH must be at least 1");
    end
  endgenerate

  // First stage is read only by the second stage
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      meta_r <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : level_sync

// [core/phy_power_ctrl_defines.svh]
// Offsets, field positions, reset values and timing figures of the
// power and test control register.
// Assumes inclusion by bare name from the core sources.
`ifndef PHY_POWER_CTRL_DEFINES_SVH
`define PHY_POWER_CTRL_DEFINES_SVH

////////////////////////////////////////////////////////////////////////
// Management address map
`define MGMT_ADDR_W 5
`define MGMT_DATA_W 16
`define PWR_TEST_CTRL_OFFSET 5'h11

////////////////////////////////////////////////////////////////////////
// Field positions
`define FLD_CLK_OFF 15
`define FLD_PS_EN 14
`define FLD_PS_SEL_HI 13
`define FLD_PS_SEL_LO 12
`define FLD_SCR_BYPASS 11
`define FLD_RSVD_10 10
`define FLD_LB_DEPTH_HI 9
`define FLD_LB_DEPTH_LO 8
`define FLD_FD_COL 4

////////////////////////////////////////////////////////////////////////
// Reset values
`define PWR_TEST_CTRL_RESET 16'h0100
`define LB_DEPTH_RESET 2'h1

////////////////////////////////////////////////////////////////////////
// Loopback FIFO depths in nibbles
`define LB_NIBBLES_00 4'h4
`define LB_NIBBLES_01 4'h5
`define LB_NIBBLES_10 4'h6
`define LB_NIBBLES_11 4'h8

////////////////////////////////////////////////////////////////////////
// Timing
`define CLK_FREQ_KHZ 40000
`define WAKE_PULSE_INTERVAL_MS 1400
`define ENERGY_QUAL_CYCLES 8

`endif

// [core/phy_power_ctrl_pkg.sv]
// Types shared by the power and test control logic.
// Assumes the defines header is available on the include path.
`include "phy_power_ctrl_defines.svh"

package phy_power_ctrl_pkg;

  // Power save select encodings
  typedef enum logic [1:0]
  {
    PS_SEL_NORMAL = 2'h0,
    PS_SEL_STD_POWER_DOWN = 2'h1,
    PS_SEL_ACTIVE_SLEEP = 2'h2,
    PS_SEL_PASSIVE_SLEEP = 2'h3
  } power_save_select_t;

  // Power state machine
  typedef enum logic [1:0]
  {
    ST_NORMAL,
    ST_STD_POWER_DOWN,
    ST_ACTIVE_SLEEP,
    ST_PASSIVE_SLEEP
  } power_state_t;

  // Management request from the serial port logic
  typedef struct packed
  {
    logic [`MGMT_ADDR_W-1:0] addr;
    logic [`MGMT_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } mgmt_req_t;

  // Writable fields of the control register
  typedef struct packed
  {
    logic clock_off;
    logic power_save_enable;
    power_save_select_t power_save_select;
    logic scrambler_bypass;
    logic [1:0] loopback_depth;
    logic full_duplex_collision_enable;
  } ctrl_fields_t;

endpackage : phy_power_ctrl_pkg

// [core/phy_power_test_control.sv]
// Power and test control register of a 10/100 transceiver, with the
// power-save state machine, wake pulse timer and collision gating.
// Assumes management accesses arrive on the same clock; energy detect
// comes from the analog front end and is synchronised here.
//
// Functional notes
// - Clock-off bit acts only in standards power-down
// - Select codes: normal, power-down, active, passive sleep
// - Power-down keeps only management port alive
// - Active sleep sends wake pulse every 1.4s
// - Active sleep wakes on energy detect
// - Passive sleep: no pulses, wakes on energy
// - Scrambler bypass bit bypasses 100M scrambler
// - Reserved bits ignore writes, read zero
// - Loopback depth codes give 4/5/6/8 nibbles
// - Elastic FIFO depth feeds far-end loopback
// - Full-duplex collision bit extends collision signalling
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
`include "phy_power_ctrl_defines.svh"

module phy_power_test_control
  import phy_power_ctrl_pkg::*;
#(
  parameter int unsigned WAKE_PULSE_CYCLES = `WAKE_PULSE_INTERVAL_MS * `CLK_FREQ_KHZ,
  parameter int unsigned ENERGY_QUAL_CYCLES = `ENERGY_QUAL_CYCLES
)
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire mgmt_req_t mgmt_req_in,
  output logic [`MGMT_DATA_W-1:0] mgmt_rdata_out,
  input wire logic energy_detect_in,
  input wire logic collision_raw_in,
  input wire logic full_duplex_in,
  output logic clock_disable_out,
  output logic core_power_on_out,
  output logic energy_detect_power_out,
  output logic wake_pulse_out,
  output logic scrambler_bypass_out,
  output logic [3:0] loopback_depth_nibbles_out,
  output logic collision_out,
  output power_state_t power_state_out
);

  ////////////////////////////////////////////////////////////////////////
  // Parameter checks

  generate
    if (WAKE_PULSE_CYCLES < 2)
    begin : g_bad_wake
      $error("WAKE_PULSE_CYCLES must be at least 2");
    end
    if (ENERGY_QUAL_CYCLES < 1 || ENERGY_QUAL_CYCLES > 255)
    begin : g_bad_qual
      $error("ENERGY_QUAL_CYCLES must lie in 1..255");
    end
  endgenerate

  localparam logic [31:0] WAKE_RELOAD = 32'(WAKE_PULSE_CYCLES - 1);
  localparam logic [7:0] QUAL_LAST = 8'(ENERGY_QUAL_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  ctrl_fields_t ctrl_r;
  power_state_t state_r;
  power_state_t state_nxt;
  logic energy_sync;
  logic [7:0] qual_cnt_r;
  logic energy_seen;
  logic wake_event;
  logic [31:0] wake_cnt_r;
  logic reg_hit;
  logic [`MGMT_DATA_W-1:0] read_word;

  ////////////////////////////////////////////////////////////////////////
  // Energy detect synchroniser

  level_sync
  #(
    .WIDTH(1)
  )
  level_sync_i
  (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .async_in(energy_detect_in),
    .sync_out(energy_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register decode

  assign reg_hit = (mgmt_req_in.addr == `PWR_TEST_CTRL_OFFSET);

  // Wake from either sleep mode on qualified energy
  assign energy_seen = energy_sync && (qual_cnt_r == QUAL_LAST);
  assign wake_event = energy_seen &&
                      ((state_r == ST_ACTIVE_SLEEP) || (state_r == ST_PASSIVE_SLEEP));

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ctrl_r.clock_off <= 1'b0;
      ctrl_r.power_save_enable <= 1'b0;
      ctrl_r.power_save_select <= PS_SEL_NORMAL;
      ctrl_r.scrambler_bypass <= 1'b0;
      ctrl_r.loopback_depth <= `LB_DEPTH_RESET;
      ctrl_r.full_duplex_collision_enable <= 1'b0;
    end
    else
    begin
      if (mgmt_req_in.wr && reg_hit)
      begin
        ctrl_r.clock_off <= mgmt_req_in.wdata[`FLD_CLK_OFF];
        ctrl_r.power_save_enable <= mgmt_req_in.wdata[`FLD_PS_EN];
        ctrl_r.power_save_select <=
          power_save_select_t'(mgmt_req_in.wdata[`FLD_PS_SEL_HI:`FLD_PS_SEL_LO]);
        ctrl_r.scrambler_bypass <= mgmt_req_in.wdata[`FLD_SCR_BYPASS];
        ctrl_r.loopback_depth <= mgmt_req_in.wdata[`FLD_LB_DEPTH_HI:`FLD_LB_DEPTH_LO];
        ctrl_r.full_duplex_collision_enable <= mgmt_req_in.wdata[`FLD_FD_COL];
      end
      if (wake_event)
      begin
        ctrl_r.power_save_enable <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path

  always_comb
  begin
    read_word = '0;
    read_word[`FLD_CLK_OFF] = ctrl_r.clock_off;
    read_word[`FLD_PS_EN] = ctrl_r.power_save_enable;
    read_word[`FLD_PS_SEL_HI:`FLD_PS_SEL_LO] = ctrl_r.power_save_select;
    read_word[`FLD_SCR_BYPASS] = ctrl_r.scrambler_bypass;
    read_word[`FLD_LB_DEPTH_HI:`FLD_LB_DEPTH_LO] = ctrl_r.loopback_depth;
    read_word[`FLD_FD_COL] = ctrl_r.full_duplex_collision_enable;
  end

  // Data stand for one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      mgmt_rdata_out <= '0;
    end
    else if (mgmt_req_in.rd && reg_hit)
    begin
      mgmt_rdata_out <= read_word;
    end
    else
    begin
      mgmt_rdata_out <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Energy qualification

  // Energy must be present for a run of cycles before it counts
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      qual_cnt_r <= '0;
    end
    else if (!energy_sync)
    begin
      qual_cnt_r <= '0;
    end
    else if (qual_cnt_r != QUAL_LAST)
    begin
      qual_cnt_r <= qual_cnt_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power state machine

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_NORMAL:
      begin
        if (ctrl_r.power_save_enable)
        begin
          case (ctrl_r.power_save_select)
            PS_SEL_STD_POWER_DOWN: state_nxt = ST_STD_POWER_DOWN;
            PS_SEL_ACTIVE_SLEEP: state_nxt = ST_ACTIVE_SLEEP;
            PS_SEL_PASSIVE_SLEEP: state_nxt = ST_PASSIVE_SLEEP;
            default: state_nxt = ST_NORMAL;
          endcase
        end
      end
      ST_STD_POWER_DOWN:
      begin
        if (!ctrl_r.power_save_enable ||
            ctrl_r.power_save_select != PS_SEL_STD_POWER_DOWN)
        begin
          state_nxt = ST_NORMAL;
        end
      end
      ST_ACTIVE_SLEEP:
      begin
        if (wake_event || !ctrl_r.power_save_enable ||
            ctrl_r.power_save_select != PS_SEL_ACTIVE_SLEEP)
        begin
          state_nxt = ST_NORMAL;
        end
      end
      ST_PASSIVE_SLEEP:
      begin
        if (wake_event || !ctrl_r.power_save_enable ||
            ctrl_r.power_save_select != PS_SEL_PASSIVE_SLEEP)
        begin
          state_nxt = ST_NORMAL;
        end
      end
      default:
      begin
        state_nxt = ST_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_r <= ST_NORMAL;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wake pulse timer

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      wake_cnt_r <= '0;
      wake_pulse_out <= 1'b0;
    end
    else if (state_r != ST_ACTIVE_SLEEP)
    begin
      wake_cnt_r <= WAKE_RELOAD;
      wake_pulse_out <= 1'b0;
    end
    else if (wake_cnt_r == 32'h0000_0000)
    begin
      wake_cnt_r <= WAKE_RELOAD;
      wake_pulse_out <= 1'b1;
    end
    else
    begin
      wake_cnt_r <= wake_cnt_r - 32'h0000_0001;
      wake_pulse_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power domain controls

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      clock_disable_out <= 1'b0;
      core_power_on_out <= 1'b1;
      energy_detect_power_out <= 1'b1;
      power_state_out <= ST_NORMAL;
    end
    else
    begin
      clock_disable_out <= ctrl_r.clock_off && (state_r == ST_STD_POWER_DOWN);
      core_power_on_out <= (state_r == ST_NORMAL);
      energy_detect_power_out <= (state_r != ST_STD_POWER_DOWN);
      power_state_out <= state_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Datapath controls

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      scrambler_bypass_out <= 1'b0;
      loopback_depth_nibbles_out <= `LB_NIBBLES_01;
    end
    else
    begin
      scrambler_bypass_out <= ctrl_r.scrambler_bypass;
      case (ctrl_r.loopback_depth)
        2'h0: loopback_depth_nibbles_out <= `LB_NIBBLES_00;
        2'h1: loopback_depth_nibbles_out <= `LB_NIBBLES_01;
        2'h2: loopback_depth_nibbles_out <= `LB_NIBBLES_10;
        default: loopback_depth_nibbles_out <= `LB_NIBBLES_11;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Collision gating

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      collision_out <= 1'b0;
    end
    else
    begin
      collision_out <= collision_raw_in &&
                       (!full_duplex_in || ctrl_r.full_duplex_collision_enable);
    end
  end

endmodule : phy_power_test_control

// [sim/phy_power_test_control_sva.sv]
// Assertion checker for the power and test control register ports.
// Assumes it is bound to the core and the bench holds energy low in reset.
`timescale 1ns/100ps
`include "phy_power_ctrl_defines.svh"

module phy_power_test_control_sva
  import phy_power_ctrl_pkg::*;
#(
  parameter int unsigned WAKE_PULSE_CYCLES = 20,
  parameter int unsigned ENERGY_QUAL_CYCLES = 8
)
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire mgmt_req_t mgmt_req_in,
  input wire logic [`MGMT_DATA_W-1:0] mgmt_rdata_out,
  input wire logic energy_detect_in,
  input wire logic collision_raw_in,
  input wire logic full_duplex_in,
  input wire logic clock_disable_out,
  input wire logic core_power_on_out,
  input wire logic energy_detect_power_out,
  input wire logic wake_pulse_out,
  input wire logic scrambler_bypass_out,
  input wire logic [3:0] loopback_depth_nibbles_out,
  input wire logic collision_out,
  input wire power_state_t power_state_out
);
  localparam int WAKE_BOUND = ENERGY_QUAL_CYCLES + 8;
  logic [31:0] gap_r;
  logic seen_r;
  logic asleep;
  assign asleep = power_state_out inside {ST_ACTIVE_SLEEP, ST_PASSIVE_SLEEP};
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);
  ////////////////////////////////////////////////////////////
  // Cycles since the last wake pulse
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      gap_r <= 32'h0;
    else
      gap_r <= wake_pulse_out ? 32'h0 : gap_r + 32'h1;
  end
  // A pulse already seen in the current stay in active sleep
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      seen_r <= 1'b0;
    else
      seen_r <= (power_state_out == ST_ACTIVE_SLEEP) && (seen_r || wake_pulse_out);
  end
  ////////////////////////////////////////////////////////////
  a_clock_off_gate: assert property (
    clock_disable_out |-> power_state_out == ST_STD_POWER_DOWN)
    else $error("clock disabled outside power-down");
  a_core_power_off: assert property (
    (power_state_out != ST_NORMAL)[*3] |-> !core_power_on_out)
    else $error("core powered in low power state");
  a_energy_power_kept: assert property (
    asleep[*3] |-> energy_detect_power_out)
    else $error("energy detector unpowered in sleep");
  a_pulse_only_active: assert property (
    wake_pulse_out |-> power_state_out == ST_ACTIVE_SLEEP)
    else $error("wake pulse outside active sleep");
  a_pulse_period: assert property (
    wake_pulse_out && seen_r |-> gap_r == WAKE_PULSE_CYCLES - 1)
    else $error("wake pulse spacing wrong");
  a_wake_on_energy: assert property (
    asleep && energy_detect_in |-> ##[1:WAKE_BOUND] (power_state_out == ST_NORMAL
    || !energy_detect_in))
    else $error("no wake on energy");
  a_reserved_zero: assert property (
    mgmt_rdata_out[10] == 1'b0 && mgmt_rdata_out[7:5] == 3'h0)
    else $error("reserved bits read nonzero");
  a_depth_legal: assert property (
    loopback_depth_nibbles_out inside {4'h4, 4'h5, 4'h6, 4'h8})
    else $error("illegal loopback depth");
  a_col_half_duplex: assert property (
    $past(collision_raw_in && !full_duplex_in) |-> collision_out)
    else $error("half duplex collision lost");
  a_col_quiet: assert property (
    $past(!collision_raw_in) |-> !collision_out)
    else $error("collision without cause");
  a_rdata_idle: assert property (
    !$past(mgmt_req_in.rd) |-> mgmt_rdata_out == 16'h0000)
    else $error("read data outside read slot");
endmodule : phy_power_test_control_sva

bind phy_power_test_control phy_power_test_control_sva #(
  .WAKE_PULSE_CYCLES(WAKE_PULSE_CYCLES),
  .ENERGY_QUAL_CYCLES(ENERGY_QUAL_CYCLES)
) phy_power_test_control_sva_i (.clk_in, .rstn_in, .mgmt_req_in, .mgmt_rdata_out,
  .energy_detect_in, .collision_raw_in, .full_duplex_in, .clock_disable_out,
  .core_power_on_out, .energy_detect_power_out, .wake_pulse_out,
  .scrambler_bypass_out, .loopback_depth_nibbles_out, .collision_out, .power_state_out);

// [sim/phy_power_test_control_test.sv]
// Self-checking bench for the power and test control register.
// Assumes a short wake pulse interval so sleep runs stay brief.
`timescale 1ns/100ps
`include "phy_power_ctrl_defines.svh"

module phy_power_test_control_test
  import phy_power_ctrl_pkg::*;
;
  localparam int unsigned WAKE = 20;
  localparam logic [3:0] NIB_TAB [4] = '{4'h4, 4'h5, 4'h6, 4'h8};
  localparam power_state_t ST_TAB [4] = '{ST_NORMAL, ST_STD_POWER_DOWN,
    ST_ACTIVE_SLEEP, ST_PASSIVE_SLEEP};
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  mgmt_req_t req = '0;
  logic energy = 1'b0;
  logic col_raw = 1'b0;
  logic fd = 1'b0;
  logic [15:0] rdata;
  logic clk_dis, core_on, ed_pwr, pulse, byp, col;
  logic [3:0] nib;
  power_state_t st;
  logic [15:0] exp_q [$];
  logic rd_seen = 1'b0;
  logic [15:0] d;
  int num_errors = 0;
  int comparisons = 0;
  int seed = 20;
  int i, c;

  phy_power_test_control #(.WAKE_PULSE_CYCLES(WAKE), .ENERGY_QUAL_CYCLES(8))
  phy_power_test_control_i (.clk_in, .rstn_in, .mgmt_req_in(req), .mgmt_rdata_out(rdata),
    .energy_detect_in(energy), .collision_raw_in(col_raw), .full_duplex_in(fd),
    .clock_disable_out(clk_dis), .core_power_on_out(core_on),
    .energy_detect_power_out(ed_pwr), .wake_pulse_out(pulse), .scrambler_bypass_out(byp),
    .loopback_depth_nibbles_out(nib), .collision_out(col), .power_state_out(st));

  always #12.5 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////
  task check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task give_verdict;
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict

  task acc(input logic w, input logic r, input logic [4:0] a, input logic [15:0] v);
    @(posedge clk_in);
    req <= '{a, v, w, r};
    @(posedge clk_in);
    req <= '0;
  endtask : acc

  task rd(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    acc(1'b0, 1'b1, a, 16'h0000);
  endtask : rd

  task settle(input int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask : settle

  // Read results are compared in the slot after the read
  always @(posedge clk_in) rd_seen <= req.rd;
  always @(negedge clk_in)
    if (rd_seen && exp_q.size() > 0)
      check(rdata, exp_q.pop_front());
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'b1;
    rd(5'h11, 16'h0100);
    acc(1'b1, 1'b0, 5'h11, 16'hFFFF);
    rd(5'h11, 16'hFB10);
    acc(1'b1, 1'b0, 5'h10, 16'h0000);
    rd(5'h12, 16'h0000);
    rd(5'h11, 16'hFB10);
    // random contents, software picks each depth
    for (i = 0; i < 12; i++)
    begin
      d = 16'($random(seed));
      d[14] = 1'b0;
      d[9:8] = i[1:0];
      acc(1'b1, 1'b0, 5'h11, d);
      rd(5'h11, d & 16'hBB10);
      @(negedge clk_in);
      check(byp, d[11]);
      check(nib, NIB_TAB[d[9:8]]);
    end
    for (i = 0; i < 4; i++)
    begin
      acc(1'b1, 1'b0, 5'h11, {2'b11, i[1:0], 12'h000});
      settle(4);
      check(st, ST_TAB[i]);
      check(clk_dis, i == 1);
      check(core_on, i == 0);
      check(ed_pwr, i != 1);
      acc(1'b1, 1'b0, 5'h11, {2'b10, i[1:0], 12'h000});
      settle(4);
      check(st, ST_NORMAL);
    end
    acc(1'b1, 1'b0, 5'h11, 16'h5000);
    settle(4);
    check(clk_dis, 1'b0);
    check(st, ST_STD_POWER_DOWN);
    rd(5'h11, 16'h5000);
    // pulse counts (two in active, none in passive) and wake in both sleeps
    for (i = 2; i < 4; i++)
    begin
      acc(1'b1, 1'b0, 5'h11, {2'b01, i[1:0], 12'h000});
      c = 0;
      repeat (55)
      begin
        @(negedge clk_in);
        if (pulse === 1'b1)
          c++;
      end
      check(c[15:0], (i == 2) ? 16'h0002 : 16'h0000);
      @(posedge clk_in);
      energy <= 1'b1;
      for (c = 0; c < 40 && st !== ST_NORMAL; c++)
        @(negedge clk_in);
      if (c == 40)
      begin
        num_errors++;
        give_verdict();
      end
      @(posedge clk_in);
      energy <= 1'b0;
      rd(5'h11, {2'b00, i[1:0], 12'h000});
    end
    for (i = 0; i < 8; i++)
    begin
      acc(1'b1, 1'b0, 5'h11, {11'h000, i[2], 4'h0});
      @(posedge clk_in);
      col_raw <= i[0];
      fd <= i[1];
      settle(2);
      check(col, i[0] & (~i[1] | i[2]));
    end
    acc(1'b1, 1'b0, 5'h11, 16'hFFFF);
    @(posedge clk_in);
    col_raw <= 1'b0;
    rstn_in <= 1'b0;
    settle(2);
    check(nib, `LB_NIBBLES_01);
    check(st, ST_NORMAL);
    check({clk_dis, core_on, ed_pwr, pulse, byp, col}, 6'b011000);
    check(rdata, 16'h0000);
    @(posedge clk_in);
    rstn_in <= 1'b1;
    rd(5'h11, 16'h0100);
    settle(1);
    give_verdict();
  end
endmodule : phy_power_test_control_test
